// ===== design/esr_regs.vh
`ifndef ESR_REGS_VH
`define ESR_REGS_VH

// Register byte offsets
`define ESR_REG_RST 5'h00
`define ESR_REG_ISO 5'h04
`define ESR_REG_TMO 5'h08
`define ESR_REG_STAT 5'h0C
`define ESR_REG_CLR 5'h10
`define ESR_REG_EN 5'h14

// Field positions
`define ESR_RST_ENTER 0
`define ESR_ISO_REQ 0
`define ESR_ST_WTMO 0
`define ESR_ST_RTMO 1
`define ESR_ST_ACC 2
`define ESR_ST_OVF 3

// Reset values
`define ESR_TMO_RST 16'h0400
`define ESR_TMO_OFF 16'h0000
`define ESR_EN_RST 3'h0
`define ESR_STAT_RST 4'h0

// Transaction handling modes
`define ESR_M_NORM 2'h0
`define ESR_M_SYNTH 2'h1
`define ESR_M_SINK 2'h2

// Response encodings
`define ESR_RESP_OKAY 2'h0
`define ESR_RESP_SLVERR 2'h2

// Packed channel widths
`define ESR_W_DW 37
`define ESR_B_DW 2
`define ESR_R_DW 35

// Small step constants
`define ESR_ONE16 16'h0001
`define ESR_ONE5 5'h01
`define ESR_ZERO5 5'h00

`endif

// ===== design/esr_slice.v
`timescale 1ns/1ps
module esr_slice #(
    parameter DW = 8
) (
    input wire clk_i, // clock
    input wire rst_n_i, // async reset, active low
    input wire ce_i, // clock enable
    input wire in_valid_i, // beat offered
    output wire in_ready_o, // beat accepted (registered)
    input wire [DW-1:0] in_data_i, // beat payload
    input wire sink_i, // accept and drop offered beats
    input wire inj_valid_i, // internal beat to insert
    input wire [DW-1:0] inj_data_i, // internal beat payload
    output wire inj_taken_o, // internal beat stored this cycle
    output wire out_valid_o, // beat held (registered)
    input wire out_ready_i, // beat taken downstream
    output wire [DW-1:0] out_data_o // held payload (registered)
);
    reg full;
    reg rdy;
    reg [DW-1:0] data;
    reg next_full;
    reg [DW-1:0] next_data;

    assign out_valid_o = full;
    assign out_data_o = data;
    assign in_ready_o = rdy;
    assign inj_taken_o = ce_i & ~full & inj_valid_i;

    // Half rate stage: simple, and every output but inj_taken_o is a flop
    always @* begin
        next_full = full;
        next_data = data;
        if (full) begin
            if (out_ready_i) begin
                next_full = 1'b0;
            end
        end else if (inj_valid_i) begin
            next_full = 1'b1;
            next_data = inj_data_i;
        end else if (in_valid_i & rdy & ~sink_i) begin
            next_full = 1'b1;
            next_data = in_data_i;
        end
    end

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            full <= 1'b0;
            rdy <= 1'b0;
            data <= {DW{1'b0}};
        end else if (ce_i) begin
            full <= next_full;
            data <= next_data;
            rdy <= sink_i | ~next_full;
        end
    end
endmodule // esr_slice

// ===== design/esr_endpoint.v
`timescale 1ns/1ps
`include "esr_regs.vh"
// Overview of operation
// - A transfer stalled past the timeout gates the external side by itself.
// - Entry port write stall: missing write beats are made with zero strobes.
// - After entry write timeout, write response forwarded once it returns.
// - Writing soft reset enter drives the external reset output high.
// - A channel stalled for the timeout period raises an interrupt.
// - Entry port read stall: remaining read beats dropped, request completed.
// - Exit port write stall: remaining beats dropped, error response returned.
// - Exit port read stall: remaining beats made with zero data and error.
// - A request arriving while isolated gets an error and an interrupt.
// - Status shows which channel timed out and an overflow flag.
// - Software can mask every interrupt through the enable register.
// - Writing soft reset exit leaves the mode and drops the reset output.
// - Isolation waits for outstanding work; new requests loop back errors.
// - Responses made by the endpoint itself carry the subordinate error.
module esr_endpoint #(
    parameter EXIT_SIDE = 1'b0 // 0: entry port, 1: exit port
) (
    input wire clk_i, // clock, 100 MHz
    input wire rst_n_i, // async reset, active low
    input wire ce_i, // clock enable, freezes all state when low
    input wire [4:0] reg_addr_i, // register byte address
    input wire [31:0] reg_wdata_i, // register write data
    input wire reg_wr_i, // register write strobe
    input wire reg_rd_i, // register read strobe
    output wire [31:0] reg_rdata_o, // read data, cycle after strobe
    output wire irq_o, // interrupt, level
    output wire ext_srst_o, // soft reset to attached device
    input wire up_req_valid_i, // request from manager side
    output wire up_req_ready_o, // request taken
    input wire up_req_write_i, // request is a write
    input wire [3:0] up_req_len_i, // beats minus one
    output wire dn_req_valid_o, // request to subordinate side
    input wire dn_req_ready_i, // request taken downstream
    output wire dn_req_write_o, // forwarded direction
    output wire [3:0] dn_req_len_o, // forwarded length
    input wire up_w_valid_i, // write beat in
    output wire up_w_ready_o, // write beat taken
    input wire [31:0] up_w_data_i, // write data in
    input wire [3:0] up_w_strb_i, // byte strobes in
    input wire up_w_last_i, // last write beat in
    output wire dn_w_valid_o, // write beat out
    input wire dn_w_ready_i, // write beat taken downstream
    output wire [31:0] dn_w_data_o, // write data out
    output wire [3:0] dn_w_strb_o, // byte strobes out
    output wire dn_w_last_o, // last write beat out
    input wire dn_b_valid_i, // write response in
    output wire dn_b_ready_o, // write response taken
    input wire [1:0] dn_b_resp_i, // write response code in
    output wire up_b_valid_o, // write response out
    input wire up_b_ready_i, // write response taken upstream
    output wire [1:0] up_b_resp_o, // write response code out
    input wire dn_r_valid_i, // read beat in
    output wire dn_r_ready_o, // read beat taken
    input wire [31:0] dn_r_data_i, // read data in
    input wire [1:0] dn_r_resp_i, // read response in
    input wire dn_r_last_i, // last read beat in
    output wire up_r_valid_o, // read beat out
    input wire up_r_ready_i, // read beat taken upstream
    output wire [31:0] up_r_data_o, // read data out
    output wire [1:0] up_r_resp_o, // read response out
    output wire up_r_last_o // last read beat out
);
    function esr_sel;
        input [4:0] addr;
        input [4:0] off;
        begin
            esr_sel = (addr == off);
        end
    endfunction

    function [15:0] esr_count;
        input stall;
        input [15:0] c;
        begin
            esr_count = stall ? c + `ESR_ONE16 : `ESR_TMO_OFF;
        end
    endfunction

    function esr_hit;
        input [15:0] n;
        input [15:0] t;
        begin
            esr_hit = (t != `ESR_TMO_OFF) && (n == t);
        end
    endfunction

    reg srst;
    reg gated;
    reg iso_req;
    reg iso_done;
    reg irq;
    reg req_rdy;
    reg dnq_v;
    reg dnq_wr;
    reg [3:0] dnq_len;
    reg [15:0] tmo;
    reg [15:0] wcnt;
    reg [15:0] rcnt;
    reg [3:0] status;
    reg [2:0] en;
    reg [31:0] rdata;
    reg wbusy;
    reg b_inj_done;
    reg rbusy;
    reg [1:0] wmode;
    reg [1:0] rmode;
    reg [4:0] w_left;
    reg [4:0] r_left;

    wire [`ESR_W_DW-1:0] wq;
    wire [`ESR_B_DW-1:0] bq;
    wire [`ESR_R_DW-1:0] rq;
    wire w_inj_taken;
    wire b_inj_taken;
    wire r_inj_taken;

    // Soft reset or auto gating both force loopback of new requests
    wire gate = srst | gated;
    wire loop = gate | iso_req;
    wire req_fire = up_req_valid_i & req_rdy;
    wire w_in_fire = up_w_valid_i & up_w_ready_o;
    wire dn_r_fire = dn_r_valid_i & dn_r_ready_o;
    wire up_b_fire = up_b_valid_o & up_b_ready_i;
    wire w_more = (w_left != `ESR_ZERO5);
    wire r_more = (r_left != `ESR_ZERO5);

    wire w_sink = wbusy & (wmode != `ESR_M_NORM);
    wire w_inj = wbusy & (wmode == `ESR_M_SYNTH) & w_more;
    wire [`ESR_W_DW-1:0] w_inj_data = {32'h00000000, 4'h0,
                                       (w_left == `ESR_ONE5)};
    wire b_sink = wbusy & (wmode == `ESR_M_SINK);
    wire b_inj = b_sink & ~w_more & ~b_inj_done;
    wire r_sink = rbusy & (rmode != `ESR_M_NORM);
    wire r_inj = rbusy & (rmode == `ESR_M_SYNTH) & r_more;
    wire [`ESR_R_DW-1:0] r_inj_data = {32'h00000000, `ESR_RESP_SLVERR,
                                       (r_left == `ESR_ONE5)};

    wire w_beat = w_more & ((wmode == `ESR_M_SYNTH) ? w_inj_taken :
                  (wbusy & w_in_fire));
    wire r_beat = r_more & ((rmode == `ESR_M_SYNTH) ? r_inj_taken :
                  (rbusy & dn_r_fire));

    // Only far side hold-ups count; our own back-pressure never times out
    wire w_stall = wbusy & (wmode == `ESR_M_NORM) &
        (EXIT_SIDE ? (dn_w_valid_o & ~dn_w_ready_i) :
                     (w_more & up_w_ready_o & ~up_w_valid_i));
    wire r_stall = rbusy & (rmode == `ESR_M_NORM) &
        (EXIT_SIDE ? (r_more & dn_r_ready_o & ~dn_r_valid_i) :
                     (up_r_valid_o & ~up_r_ready_i));
    wire [15:0] next_wcnt = esr_count(w_stall, wcnt);
    wire [15:0] next_rcnt = esr_count(r_stall, rcnt);
    wire wto_ev = esr_hit(next_wcnt, tmo);
    wire rto_ev = esr_hit(next_rcnt, tmo);
    wire acc_ev = req_fire & loop;

    wire wr_rst = reg_wr_i & esr_sel(reg_addr_i, `ESR_REG_RST);
    wire wr_iso = reg_wr_i & esr_sel(reg_addr_i, `ESR_REG_ISO);
    wire wr_tmo = reg_wr_i & esr_sel(reg_addr_i, `ESR_REG_TMO);
    wire wr_clr = reg_wr_i & esr_sel(reg_addr_i, `ESR_REG_CLR);
    wire wr_en = reg_wr_i & esr_sel(reg_addr_i, `ESR_REG_EN);
    wire srst_enter = wr_rst & reg_wdata_i[`ESR_RST_ENTER];

    // Clear and new event in one cycle: the event stays
    wire [3:0] clr = wr_clr ? reg_wdata_i[3:0] : 4'h0;
    wire [2:0] ev = {acc_ev, rto_ev, wto_ev};
    wire [2:0] kept = status[2:0] & ~clr[2:0];
    wire ev_multi = (ev[0] & ev[1]) | (ev[0] & ev[2]) | (ev[1] & ev[2]);
    wire next_ovf = (status[`ESR_ST_OVF] & ~clr[`ESR_ST_OVF]) |
                    ev_multi | ((|ev) & (|kept));
    wire [2:0] next_flags = kept | ev;
    wire [2:0] next_en = wr_en ? reg_wdata_i[2:0] : en;

    assign reg_rdata_o = rdata;
    assign irq_o = irq;
    assign ext_srst_o = srst;
    assign up_req_ready_o = req_rdy;
    assign dn_req_valid_o = dnq_v;
    assign dn_req_write_o = dnq_wr;
    assign dn_req_len_o = dnq_len;
    assign dn_w_data_o = wq[36:5];
    assign dn_w_strb_o = wq[4:1];
    assign dn_w_last_o = wq[0];
    assign up_b_resp_o = bq;
    assign up_r_data_o = rq[34:3];
    assign up_r_resp_o = rq[2:1];
    assign up_r_last_o = rq[0];

    esr_slice #(.DW(`ESR_W_DW)) u_wslice (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .in_valid_i(up_w_valid_i),
        .in_ready_o(up_w_ready_o),
        .in_data_i({up_w_data_i, up_w_strb_i, up_w_last_i}),
        .sink_i(w_sink),
        .inj_valid_i(w_inj),
        .inj_data_i(w_inj_data),
        .inj_taken_o(w_inj_taken),
        .out_valid_o(dn_w_valid_o),
        .out_ready_i(dn_w_ready_i),
        .out_data_o(wq)
    );

    esr_slice #(.DW(`ESR_B_DW)) u_bslice (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .in_valid_i(dn_b_valid_i),
        .in_ready_o(dn_b_ready_o),
        .in_data_i(dn_b_resp_i),
        .sink_i(b_sink),
        .inj_valid_i(b_inj),
        .inj_data_i(`ESR_RESP_SLVERR),
        .inj_taken_o(b_inj_taken),
        .out_valid_o(up_b_valid_o),
        .out_ready_i(up_b_ready_i),
        .out_data_o(bq)
    );

    esr_slice #(.DW(`ESR_R_DW)) u_rslice (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .in_valid_i(dn_r_valid_i),
        .in_ready_o(dn_r_ready_o),
        .in_data_i({dn_r_data_i, dn_r_resp_i, dn_r_last_i}),
        .sink_i(r_sink),
        .inj_valid_i(r_inj),
        .inj_data_i(r_inj_data),
        .inj_taken_o(r_inj_taken),
        .out_valid_o(up_r_valid_o),
        .out_ready_i(up_r_ready_i),
        .out_data_o(rq)
    );

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            srst <= 1'b0;
            gated <= 1'b0;
            iso_req <= 1'b0;
            iso_done <= 1'b0;
            irq <= 1'b0;
            req_rdy <= 1'b0;
            dnq_v <= 1'b0;
            dnq_wr <= 1'b0;
            dnq_len <= 4'h0;
            tmo <= `ESR_TMO_RST;
            wcnt <= `ESR_TMO_OFF;
            rcnt <= `ESR_TMO_OFF;
            status <= `ESR_STAT_RST;
            en <= `ESR_EN_RST;
            rdata <= 32'h00000000;
            wbusy <= 1'b0;
            b_inj_done <= 1'b0;
            rbusy <= 1'b0;
            wmode <= `ESR_M_NORM;
            rmode <= `ESR_M_NORM;
            w_left <= `ESR_ZERO5;
            r_left <= `ESR_ZERO5;
        end else if (ce_i) begin
            if (wr_rst) begin
                if (reg_wdata_i[`ESR_RST_ENTER]) begin
                    srst <= 1'b1;
                end else begin
                    srst <= 1'b0;
                    gated <= 1'b0;
                end
            end
            if (wr_iso) begin
                iso_req <= reg_wdata_i[`ESR_ISO_REQ];
            end
            if (wr_tmo) begin
                tmo <= reg_wdata_i[15:0];
            end
            en <= next_en;
            status <= {next_ovf, next_flags};
            irq <= |(next_flags & next_en);
            // Isolation counts as entered only once nothing is in flight
            iso_done <= iso_req & ~wbusy & ~rbusy & ~dnq_v;
            rdata <= 32'h00000000;
            if (reg_rd_i) begin
                case (reg_addr_i)
                    `ESR_REG_RST: rdata <= {30'h00000000, gated, srst};
                    `ESR_REG_ISO: rdata <= {30'h00000000, iso_done, iso_req};
                    `ESR_REG_TMO: rdata <= {16'h0000, tmo};
                    `ESR_REG_STAT: rdata <= {28'h0000000, status};
                    `ESR_REG_EN: rdata <= {29'h00000000, en};
                    default: rdata <= 32'h00000000;
                endcase
            end

            // One transaction in flight keeps loopback ordering trivial
            if (req_fire) begin
                req_rdy <= 1'b0;
            end else if (~wbusy & ~rbusy & ~dnq_v) begin
                req_rdy <= 1'b1;
            end
            if (dnq_v & dn_req_ready_i) begin
                dnq_v <= 1'b0;
            end
            if (req_fire & ~loop) begin
                dnq_v <= 1'b1;
                dnq_wr <= up_req_write_i;
                dnq_len <= up_req_len_i;
            end

            wcnt <= next_wcnt;
            rcnt <= next_rcnt;
            if (wto_ev | rto_ev) begin
                gated <= 1'b1;
            end

            if (req_fire & up_req_write_i) begin
                wbusy <= 1'b1;
                b_inj_done <= 1'b0;
                w_left <= {1'b0, up_req_len_i} + `ESR_ONE5;
                wmode <= loop ? `ESR_M_SINK : `ESR_M_NORM;
            end else begin
                if (w_beat) begin
                    w_left <= w_left - `ESR_ONE5;
                end
                if (b_inj_taken) begin
                    b_inj_done <= 1'b1;
                end
                if (wbusy & ~w_more & up_b_fire) begin
                    wbusy <= 1'b0;
                end
                if (wto_ev) begin
                    wmode <= EXIT_SIDE ? `ESR_M_SINK : `ESR_M_SYNTH;
                end else if (srst_enter & (wmode == `ESR_M_NORM)) begin
                    wmode <= `ESR_M_SINK;
                end
            end

            if (req_fire & ~up_req_write_i) begin
                rbusy <= 1'b1;
                r_left <= {1'b0, up_req_len_i} + `ESR_ONE5;
                rmode <= loop ? `ESR_M_SYNTH : `ESR_M_NORM;
            end else begin
                if (r_beat) begin
                    r_left <= r_left - `ESR_ONE5;
                end
                if (rbusy & ~r_more) begin
                    rbusy <= 1'b0;
                end
                if (rto_ev) begin
                    rmode <= EXIT_SIDE ? `ESR_M_SYNTH : `ESR_M_SINK;
                end else if (srst_enter & (rmode == `ESR_M_NORM)) begin
                    rmode <= `ESR_M_SYNTH;
                end
            end
        end
    end
endmodule // esr_endpoint

// ===== verification/esr_endpoint_sva.sv
`timescale 1ns/1ps
`include "esr_regs.vh"
module esr_endpoint_sva (
    input wire clk_i, // clock
    input wire rst_n_i, // reset, low
    input wire [4:0] reg_addr_i, // reg address
    input wire [31:0] reg_wdata_i, // reg write data
    input wire reg_wr_i, // write strobe
    input wire reg_rd_i, // read strobe
    input wire [31:0] reg_rdata_o, // read data
    input wire irq_o, // interrupt
    input wire ext_srst_o, // soft reset out
    input wire up_req_valid_i, // request offered
    input wire up_req_ready_o, // request taken
    input wire dn_req_valid_o, // request forwarded
    input wire up_b_valid_o, // response out
    input wire up_b_ready_i, // response taken
    input wire [1:0] up_b_resp_o, // response code
    input wire up_r_valid_o, // read beat out
    input wire up_r_ready_i, // read beat taken
    input wire [31:0] up_r_data_o // read data out
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    wire rst_wr = reg_wr_i && reg_addr_i == `ESR_REG_RST;
    wire take = up_req_valid_i && up_req_ready_o;

    rdata_idle_a: assert property (
        !$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
        else $error("read data outside its slot");
    srst_enter_a: assert property (
        rst_wr && reg_wdata_i[0] |=> ext_srst_o)
        else $error("soft reset output not raised");
    srst_exit_a: assert property (
        rst_wr && !reg_wdata_i[0] |=> !ext_srst_o)
        else $error("soft reset output not dropped");
    srst_hold_a: assert property (
        !$past(rst_wr) |-> $stable(ext_srst_o))
        else $error("soft reset output moved by itself");
    irq_mask_a: assert property (
        reg_wr_i && reg_addr_i == `ESR_REG_EN && reg_wdata_i[2:0] == 3'h0
        |=> !irq_o)
        else $error("interrupt not masked");
    irq_sticky_a: assert property (
        $fell(irq_o) |-> $past(reg_wr_i))
        else $error("interrupt dropped without software");
    loop_nodn_a: assert property (
        take && ext_srst_o |=> !dn_req_valid_o [*2])
        else $error("request forwarded during soft reset");
    one_flight_a: assert property (
        take |=> !up_req_ready_o)
        else $error("second request accepted in flight");
    b_hold_a: assert property (
        up_b_valid_o && !up_b_ready_i |=> up_b_valid_o && $stable(up_b_resp_o))
        else $error("write response not held");
    r_hold_a: assert property (
        up_r_valid_o && !up_r_ready_i |=> up_r_valid_o && $stable(up_r_data_o))
        else $error("read beat not held");
endmodule // esr_endpoint_sva

bind esr_endpoint esr_endpoint_sva esr_endpoint_sva_inst (.clk_i, .rst_n_i,
    .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .irq_o,
    .ext_srst_o, .up_req_valid_i, .up_req_ready_o, .dn_req_valid_o,
    .up_b_valid_o, .up_b_ready_i, .up_b_resp_o, .up_r_valid_o, .up_r_ready_i,
    .up_r_data_o);

// ===== verification/esr_sub_model.sv
`timescale 1ns/1ps
module esr_sub_model (
    input logic clk_i, // clock
    input logic rst_n_i, // reset, low
    input logic srst_i, // soft reset from endpoint
    input logic hold_i, // stall after two beats
    input logic req_valid_i, // request offered
    input logic req_write_i, // request is write
    input logic [3:0] req_len_i, // beats minus one
    output logic req_ready_o, // request taken
    input logic w_valid_i, // write beat offered
    input logic w_last_i, // last write beat
    output logic w_ready_o, // write beat taken
    output logic b_valid_o, // write response
    output logic [1:0] b_resp_o, // response code
    input logic b_ready_i, // response taken
    output logic r_valid_o, // read beat
    output logic [31:0] r_data_o, // read data
    output logic [1:0] r_resp_o, // read response
    output logic r_last_o, // last read beat
    input logic r_ready_i // read beat taken
);
    logic [4:0] wn, rn, rleft;
    wire mrst_n = rst_n_i & ~srst_i;
    wire [31:0] pat = 32'hA5000000 + {27'h0, rn};

    // Soft reset pin clears the device like a power-on reset
    always_ff @(posedge clk_i or negedge mrst_n) begin
        if (!mrst_n) begin
            wn <= 5'h00;
            rn <= 5'h00;
            rleft <= 5'h00;
            b_valid_o <= 1'b0;
        end else begin
            if (req_valid_i && req_ready_o) begin
                wn <= 5'h00;
                rn <= 5'h00;
                rleft <= req_write_i ? 5'h00 : {1'b0, req_len_i} + 5'h01;
            end
            if (w_valid_i && w_ready_o) begin
                wn <= wn + 5'h01;
                if (w_last_i) b_valid_o <= 1'b1;
            end
            if (b_valid_o && b_ready_i) b_valid_o <= 1'b0;
            if (r_valid_o && r_ready_i) begin
                rn <= rn + 5'h01;
                rleft <= rleft - 5'h01;
            end
        end
    end
    assign req_ready_o = 1'b1;
    // A hung device stops after the second beat while held
    assign w_ready_o = !(hold_i && wn >= 5'h02);
    assign r_valid_o = rleft != 5'h00 && !(hold_i && rn >= 5'h02);
    // Idle lines carry garbage, not the last value
    assign r_data_o = r_valid_o ? pat : ~pat;
    assign r_resp_o = r_valid_o ? 2'h0 : 2'h3;
    assign r_last_o = rleft == 5'h01;
    assign b_resp_o = b_valid_o ? 2'h0 : 2'h3;
endmodule // esr_sub_model

// ===== verification/esr_endpoint_bench.sv
`timescale 1ns/1ps
`include "esr_regs.vh"
module esr_endpoint_bench;
    logic clk_i = 0, rst_n_i = 0, ce_i = 1, hold = 0;
    logic [4:0] reg_addr_i = 0;
    logic [31:0] reg_wdata_i = 0, up_w_data_i = 0;
    logic reg_wr_i = 0, reg_rd_i = 0, up_req_valid_i = 0, up_req_write_i = 0;
    logic [3:0] up_req_len_i = 0, up_w_strb_i = 0, dn_req_len_o, dn_w_strb_o;
    logic up_w_valid_i = 0, up_w_last_i = 0, up_b_ready_i = 0, up_r_ready_i = 0;
    logic [31:0] reg_rdata_o, dn_w_data_o, dn_r_data_i, up_r_data_o;
    logic irq_o, ext_srst_o, up_req_ready_o, dn_req_valid_o, dn_req_ready_i;
    logic dn_req_write_o, up_w_ready_o, dn_w_valid_o, dn_w_ready_i, dn_w_last_o;
    logic dn_b_valid_i, dn_b_ready_o, up_b_valid_o, dn_r_valid_i, dn_r_ready_o;
    logic dn_r_last_i, up_r_valid_o, up_r_last_o;
    logic [1:0] dn_b_resp_i, up_b_resp_o, dn_r_resp_i, up_r_resp_o;
    int bad_count = 0, n_compared = 0;
    localparam logic [1:0] OK = `ESR_RESP_OKAY, ERR = `ESR_RESP_SLVERR;

    esr_endpoint #(.EXIT_SIDE(1'b1)) esr_endpoint_inst (.*);
    esr_sub_model esr_sub_model_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .srst_i(ext_srst_o), .hold_i(hold), .req_valid_i(dn_req_valid_o),
        .req_write_i(dn_req_write_o), .req_len_i(dn_req_len_o),
        .req_ready_o(dn_req_ready_i), .w_valid_i(dn_w_valid_o),
        .w_last_i(dn_w_last_o), .w_ready_o(dn_w_ready_i),
        .b_valid_o(dn_b_valid_i), .b_resp_o(dn_b_resp_i),
        .b_ready_i(dn_b_ready_o), .r_valid_o(dn_r_valid_i),
        .r_data_o(dn_r_data_i), .r_resp_o(dn_r_resp_i),
        .r_last_o(dn_r_last_i), .r_ready_i(dn_r_ready_o));

    always #5 clk_i = ~clk_i;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wreg(input logic [4:0] a, input logic [31:0] d);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask

    task automatic rreg(input logic [4:0] a, input logic [31:0] exp);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        #1 chk(reg_rdata_o, exp);
    endtask

    task automatic wait_on(ref logic s);
        int k;
        k = 0;
        do @(posedge clk_i); while (s !== 1'b1 && ++k < 200);
        // A limit that runs out is a mismatch, so a hang never passes
        if (s !== 1'b1) begin
            bad_count++;
            $display("Error at %0t: stuck %h expected %h", $time, s, 1'b1);
        end
    endtask

    // First okb read beats are real, the rest synthesized with code er
    task automatic txn(input logic w, input logic [3:0] len,
                       input logic [1:0] er, input int okb);
        @(posedge clk_i);
        up_req_valid_i <= 1'b1;
        up_req_write_i <= w;
        up_req_len_i <= len;
        wait_on(up_req_ready_o);
        up_req_valid_i <= 1'b0;
        for (int i = 0; i <= len && w; i++) begin
            up_w_valid_i <= 1'b1;
            up_w_data_i <= 32'(i);
            up_w_strb_i <= 4'hF;
            up_w_last_i <= (i == len);
            wait_on(up_w_ready_o);
        end
        up_w_valid_i <= 1'b0;
        for (int i = 0; i <= len; i++) begin
            if (w) wait_on(up_b_valid_o);
            else wait_on(up_r_valid_o);
            if (w) chk({30'h0, up_b_resp_o}, {30'h0, er});
            else if (i < okb) chk(up_r_data_o, 32'hA5000000 + i);
            else chk(up_r_data_o, 32'h0);
            if (!w) chk({30'h0, up_r_resp_o},
                        {30'h0, i < okb ? OK : er});
            if (!w) chk({31'h0, up_r_last_o}, {31'h0, i == len});
            up_b_ready_i <= w;
            up_r_ready_i <= !w;
            @(posedge clk_i);
            up_b_ready_i <= 1'b0;
            up_r_ready_i <= 1'b0;
            if (w) break;
        end
    endtask

    task automatic t_reset;
        rreg(`ESR_REG_TMO, 32'h400);
        rreg(`ESR_REG_EN, 32'h0);
        rreg(`ESR_REG_STAT, 32'h0);
        rreg(`ESR_REG_CLR, 32'h0);
        rreg(5'h18, 32'h0);
        txn(1'b1, 4'h3, OK, 4);
        txn(1'b0, 4'h3, OK, 4);
        $display("reset and pass-through done");
    endtask

    task automatic t_wstall;
        wreg(`ESR_REG_TMO, 32'h8);
        wreg(`ESR_REG_EN, 32'h7);
        hold <= 1'b1;
        txn(1'b1, 4'h3, ERR, 0);
        rreg(`ESR_REG_STAT, 32'h1);
        chk({31'h0, irq_o}, 32'h1);
        rreg(`ESR_REG_RST, 32'h2);
        wreg(`ESR_REG_RST, 32'h1);
        #1 chk({31'h0, ext_srst_o}, 32'h1);
        wreg(`ESR_REG_CLR, 32'hF);
        rreg(`ESR_REG_STAT, 32'h0);
        #1 chk({31'h0, irq_o}, 32'h0);
        wreg(`ESR_REG_RST, 32'h0);
        #1 chk({31'h0, ext_srst_o}, 32'h0);
        rreg(`ESR_REG_RST, 32'h0);
        hold <= 1'b0;
        $display("write stall done");
    endtask

    task automatic t_rstall;
        hold <= 1'b1;
        txn(1'b0, 4'h3, ERR, 2);
        rreg(`ESR_REG_STAT, 32'h2);
        wreg(`ESR_REG_RST, 32'h1);
        txn(1'b1, 4'h0, ERR, 0);
        rreg(`ESR_REG_STAT, 32'hE);
        wreg(`ESR_REG_CLR, 32'hF);
        wreg(`ESR_REG_RST, 32'h0);
        hold <= 1'b0;
        $display("read stall and soft reset done");
    endtask

    task automatic t_iso;
        wreg(`ESR_REG_ISO, 32'h1);
        rreg(`ESR_REG_ISO, 32'h3);
        txn(1'b1, 4'h0, ERR, 0);
        rreg(`ESR_REG_STAT, 32'h4);
        chk({31'h0, irq_o}, 32'h1);
        wreg(`ESR_REG_EN, 32'h0);
        #1 chk({31'h0, irq_o}, 32'h0);
        wreg(`ESR_REG_ISO, 32'h0);
        rreg(`ESR_REG_ISO, 32'h0);
        txn(1'b1, 4'h1, OK, 2);
        txn(1'b0, 4'h1, OK, 2);
        rreg(`ESR_REG_STAT, 32'h4);
        wreg(`ESR_REG_CLR, 32'h4);
        rreg(`ESR_REG_STAT, 32'h0);
        $display("isolation done");
    endtask

    task automatic results;
        $display("compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'b1;
        t_reset;
        t_wstall;
        t_rstall;
        t_iso;
        results;
    end

    // Whole run needs a few hundred cycles; this is 20000 cycles, many times that
    initial begin
        #200000;
        bad_count++;
        results;
    end
endmodule // esr_endpoint_bench
